// ===== src/cbc_cycle_ctrl.v
// What this block does
// - Pull ready low when channel ready, or time-out
// - Otherwise ready is input, never driven
// - Decode status pair into cycle type
// - Memory/IO select picks memory or I/O strobes
// - Request hold for DMA, master, refresh
// - Float all commands while hold acknowledged
// - Byte-high in on CPU, out on DMA
// - Drive active-high non-maskable interrupt
// - Internal address latch each cycle, not halt
// - Wait while channel not ready
// - Channel check raises interrupt if enabled
// - Parity error raises interrupt if enabled
// - Bus address latch on bus clock
// - Upper address latch enable, active low
// - Grant out after processor gives bus
// - ROM cycles suppress parity checking
// - Zero-wait request ends bus cycle now
`include "cbc_map.vh"
module cbc_cycle_ctrl (
    input  wire                  mclk_i,
    input  wire                  rst_n_i,
    input  wire                  s0_n_i,
    input  wire                  s1_n_i,
    input  wire                  mem_io_sel_i,
    input  wire                  addr0_i,
    input  wire                  periph_addr0_i,
    input  wire                  channel_ready_i,
    input  wire                  zero_wait_request_n_i,
    input  wire                  channel_check_n_i,
    input  wire                  parity_error_in_n_i,
    input  wire                  rom_select_in_n_i,
    input  wire                  hold_request_in_i,
    input  wire                  refresh_req_i,
    input  wire                  dma8_addr_enable_n_i,
    input  wire                  dma16_addr_enable_n_i,
    input  wire                  hlda_i,
    input  wire                  chk_nmi_en_i,
    input  wire                  par_nmi_en_i,
    input  wire                  nmi_clear_i,
    input  wire [`CBC_TOUT_W-1:0] timeout_clks_i,
    input  wire                  ready_n_i,
    output wire                  ready_n_o,
    output wire                  ready_n_oe_n_o,
    input  wire                  byte_high_enable_n_i,
    output reg                   byte_high_enable_n_o,
    output wire                  byte_high_enable_n_oe_n_o,
    output reg                   ior_n_o,
    output reg                   iow_n_o,
    output reg                   memr_n_o,
    output reg                   memw_n_o,
    output reg                   inta_n_o,
    output wire                  cmd_oe_n_o,
    output reg                   hold_o,
    output reg                   hold_grant_out_o,
    output reg                   nmi_o,
    output reg                   internal_addr_latch_enable_o,
    output reg                   bus_addr_latch_enable_o,
    output reg                   upper_addr_latch_enable_n_o,
    output reg                   cpu_high_byte_o,
    output reg                   cpu_cycle_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_CMD  = 4'b0100;
    localparam ST_END  = 4'b1000;

    reg  [3:0]             state_q;
    reg  [3:0]             state_d;
    reg  [1:0]             type_q;
    reg                    mem_q;
    reg  [`CBC_TOUT_W-1:0] tout_q;
    reg                    bclk_q;
    reg                    rdy_drv_q;
    reg                    ior_d;
    reg                    iow_d;
    reg                    memr_d;
    reg                    memw_d;
    reg                    inta_d;
    wire [1:0]             st_w;
    wire                   bus_owned;
    wire                   dma_active;
    wire                   chk_fall;
    wire                   par_fall;
    wire                   tout_hit;
    wire                   start_w;
    wire                   latch_w;
    wire                   cmd_w;
    wire                   ends_w;

    // Encodes the active-low status pair to a cycle type
    function [1:0] cbc_decode;
        input s1_n;
        input s0_n;
        begin
            cbc_decode = {s1_n, s0_n};
        end
    endfunction

    // Status 00 is a halt in memory space, an interrupt acknowledge in I/O space
    function cbc_is_halt;
        input [1:0] st;
        input       mio;
        begin
            cbc_is_halt = (st == `CBC_ST_HALT) && mio;
        end
    endfunction

    // One command strobe, low while the command phase matches its space and type
    function cbc_strobe_n;
        input       in_cmd;
        input       mem;
        input [1:0] st;
        input       want_mem;
        input [1:0] want_st;
        begin
            cbc_strobe_n = !(in_cmd && (mem == want_mem) && (st == want_st));
        end
    endfunction

    assign st_w       = cbc_decode(s1_n_i, s0_n_i);
    assign bus_owned  = hold_grant_out_o;
    assign dma_active = ~dma8_addr_enable_n_i | ~dma16_addr_enable_n_i;
    assign tout_hit   = (tout_q == timeout_clks_i) && (timeout_clks_i != 8'h00);
    assign start_w    = (state_q == ST_IDLE) && (state_d == ST_ADDR);
    // Halt cycles get no latch pulse
    assign latch_w    = (state_d == ST_ADDR) && !cbc_is_halt(st_w, mem_io_sel_i);
    assign cmd_w      = (state_d == ST_CMD);
    assign ends_w     = (state_q == ST_CMD) && (state_d == ST_END);

    cbc_sync_pulse u_chk (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .lvl_n_i (channel_check_n_i),
        .fall_o  (chk_fall)
    );

    // ROM cycles mask the parity input before it can reach the interrupt
    cbc_sync_pulse u_par (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .lvl_n_i (parity_error_in_n_i | ~rom_select_in_n_i),
        .fall_o  (par_fall)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (!bus_owned && st_w != `CBC_ST_IDLE)
                    state_d = ST_ADDR;
            end
            ST_ADDR: begin
                if (cbc_is_halt(type_q, mem_q))
                    state_d = ST_END;
                else
                    state_d = ST_CMD;
            end
            ST_CMD: begin
                // Zero-wait ends at once; otherwise wait for channel ready
                if (!zero_wait_request_n_i || channel_ready_i || tout_hit)
                    state_d = ST_END;
            end
            ST_END: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            type_q  <= `CBC_ST_IDLE;
            mem_q   <= 1'b0;
            bclk_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            bclk_q  <= ~bclk_q;
            if (start_w) begin
                type_q <= st_w;
                mem_q  <= mem_io_sel_i;
            end
        end
    end

    // Count only in the command phase, so a stale count never ends a later cycle
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            tout_q <= 8'h00;
        else if (state_q == ST_CMD)
            tout_q <= tout_q + 8'h01;
        else
            tout_q <= 8'h00;
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            internal_addr_latch_enable_o <= 1'b0;
            bus_addr_latch_enable_o      <= 1'b0;
            upper_addr_latch_enable_n_o  <= 1'b1;
        end else begin
            internal_addr_latch_enable_o <= latch_w;
            // Bus latch follows the bus-clock phase, so it may skip a cycle
            bus_addr_latch_enable_o      <= latch_w && !bclk_q;
            upper_addr_latch_enable_n_o  <= !latch_w;
        end
    end

    // Drive ready low only for the cycle this block terminates
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rdy_drv_q <= 1'b0;
        else
            rdy_drv_q <= ends_w && ((channel_ready_i && zero_wait_request_n_i) || tout_hit);
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_high_byte_o <= 1'b0;
            cpu_cycle_o     <= 1'b0;
        end else if (state_q == ST_ADDR) begin
            cpu_high_byte_o <= ~byte_high_enable_n_i & ~addr0_i;
            cpu_cycle_o     <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            cpu_cycle_o <= 1'b0;
        end
    end

    assign ready_n_o      = 1'b0;
    assign ready_n_oe_n_o = ~rdy_drv_q;

    always @* begin
        ior_d  = cbc_strobe_n(cmd_w, mem_q, type_q, 1'b0, `CBC_ST_READ);
        iow_d  = cbc_strobe_n(cmd_w, mem_q, type_q, 1'b0, `CBC_ST_WRITE);
        memr_d = cbc_strobe_n(cmd_w, mem_q, type_q, 1'b1, `CBC_ST_READ);
        memw_d = cbc_strobe_n(cmd_w, mem_q, type_q, 1'b1, `CBC_ST_WRITE);
        // Interrupt acknowledge: I/O space with halt-coded status
        inta_d = cbc_strobe_n(cmd_w, mem_q, type_q, 1'b0, `CBC_ST_HALT);
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ior_n_o  <= 1'b1;
            iow_n_o  <= 1'b1;
            memr_n_o <= 1'b1;
            memw_n_o <= 1'b1;
            inta_n_o <= 1'b1;
        end else begin
            ior_n_o  <= ior_d;
            iow_n_o  <= iow_d;
            memr_n_o <= memr_d;
            memw_n_o <= memw_d;
            inta_n_o <= inta_d;
        end
    end

    assign cmd_oe_n_o = hlda_i;

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_o               <= 1'b0;
            hold_grant_out_o     <= 1'b0;
            byte_high_enable_n_o <= 1'b1;
        end else begin
            hold_o               <= hold_request_in_i | refresh_req_i;
            // Grant passes on only after the processor releases the bus
            hold_grant_out_o     <= hlda_i & hold_request_in_i;
            byte_high_enable_n_o <= periph_addr0_i;
        end
    end

    assign byte_high_enable_n_oe_n_o = ~(bus_owned & dma_active);

    // Set wins over software clear
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            nmi_o <= 1'b0;
        else if ((chk_fall && chk_nmi_en_i) || (par_fall && par_nmi_en_i))
            nmi_o <= 1'b1;
        else if (nmi_clear_i)
            nmi_o <= 1'b0;
    end
endmodule // cbc_cycle_ctrl

// ===== src/cbc_map.vh
`ifndef CBC_MAP_VH
`define CBC_MAP_VH
// Decoded processor status (active-low pair: {s1_n, s0_n})
`define CBC_ST_HALT      2'b00
`define CBC_ST_WRITE     2'b01
`define CBC_ST_READ      2'b10
`define CBC_ST_IDLE      2'b11
// Time-out default, in processor clocks
`define CBC_TOUT_DEF     8'h40
`define CBC_TOUT_W       8
// Expansion-bus state machine clock divide (bus clock = mclk / 2)
`define CBC_BDIV_W       1
`endif

// ===== src/cbc_sync_pulse.v
module cbc_sync_pulse (
    input  wire mclk_i,
    input  wire rst_n_i,
    input  wire lvl_n_i,
    output wire fall_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Low-active level sampled twice, then edge-detected on the second stage
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= lvl_n_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign fall_o = s3_q & ~s2_q;
endmodule // cbc_sync_pulse

// ===== tb/cbc_props_properties.sv
`include "cbc_map.vh"
module cbc_props (
    input wire logic mclk_i, rst_n_i, s0_n_i, s1_n_i, channel_ready_i,
    input wire logic zero_wait_request_n_i, hold_request_in_i, refresh_req_i, hlda_i,
    input wire logic chk_nmi_en_i, par_nmi_en_i, ready_n_o, ready_n_oe_n_o, cmd_oe_n_o,
    input wire logic [`CBC_TOUT_W-1:0] timeout_clks_i,
    input wire logic byte_high_enable_n_oe_n_o, ior_n_o, iow_n_o, memr_n_o, memw_n_o,
    input wire logic inta_n_o, hold_o, nmi_o, hold_grant_out_o, mem_io_sel_i,
    input wire logic internal_addr_latch_enable_o, upper_addr_latch_enable_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire act = !(ior_n_o & iow_n_o & memr_n_o & memw_n_o & inta_n_o);
    sequence s_latch; internal_addr_latch_enable_o && !upper_addr_latch_enable_n_o; endsequence
    sequence s_done; !act && !ready_n_o ##1 ready_n_oe_n_o; endsequence
    property p_float; hlda_i |-> cmd_oe_n_o; endproperty
    a_float: assert property (p_float) else $error("command not floated");
    property p_hold; hold_request_in_i || refresh_req_i |-> ##[0:8] hold_o; endproperty
    a_hold: assert property (p_hold) else $error("no hold request");
    property p_grant; hlda_i && hold_request_in_i |=> hold_grant_out_o; endproperty
    a_grant: assert property (p_grant) else $error("no grant");
    property p_halt;
        !s1_n_i && !s0_n_i && mem_io_sel_i && !act |=> !internal_addr_latch_enable_o [*3];
    endproperty
    a_halt: assert property (p_halt) else $error("latch on halt");
    property p_walk; internal_addr_latch_enable_o |-> s_latch ##1 act; endproperty
    a_walk: assert property (p_walk) else $error("latch order");
    property p_end; $fell(ready_n_oe_n_o) |-> $past(act) ##0 s_done; endproperty
    a_end: assert property (p_end) else $error("ready drive");
    property p_wait;
        act && !channel_ready_i && zero_wait_request_n_i && timeout_clks_i == 0 |=> act;
    endproperty
    a_wait: assert property (p_wait) else $error("no wait state");
    property p_zws; act && !zero_wait_request_n_i |=> !act; endproperty
    a_zws: assert property (p_zws) else $error("zero wait ignored");
    property p_nmi; $rose(nmi_o) |-> chk_nmi_en_i || par_nmi_en_i; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi while disabled");
    property p_bhe; !byte_high_enable_n_oe_n_o |-> hold_grant_out_o; endproperty
    a_bhe: assert property (p_bhe) else $error("byte high driven");
endmodule // cbc_props
bind cbc_cycle_ctrl cbc_props u_props (.*);

// ===== tb/cbc_cpu_model.sv
module cbc_cpu_model #(parameter int LAG = 2) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic hold_i,
    output logic      hlda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // A slow core finishes its own work before giving up the bus
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i || !hold_i) begin
            cnt <= 0;
            hlda_o <= 1'b0;
        end else if (cnt < LAG) cnt <= cnt + 1;
        else hlda_o <= 1'b1;
    end
endmodule // cbc_cpu_model

// ===== tb/cbc_cycle_ctrl_tb.sv
`include "cbc_map.vh"
module cbc_cycle_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, rst_n_i = 0, s0_n_i = 1, s1_n_i = 1, mem_io_sel_i = 1, addr0_i = 0;
    logic periph_addr0_i = 0, channel_ready_i = 1, zero_wait_request_n_i = 1;
    logic channel_check_n_i = 1, parity_error_in_n_i = 1, rom_select_in_n_i = 1;
    logic hold_request_in_i = 0, refresh_req_i = 0, dma8_addr_enable_n_i = 1;
    logic dma16_addr_enable_n_i = 1, chk_nmi_en_i = 0, par_nmi_en_i = 0, nmi_clear_i = 0;
    logic ready_n_i = 1, byte_high_enable_n_i = 1;
    logic [`CBC_TOUT_W-1:0] timeout_clks_i = 8'h00;
    wire hlda_i, ready_n_o, ready_n_oe_n_o, byte_high_enable_n_o, byte_high_enable_n_oe_n_o;
    wire ior_n_o, iow_n_o, memr_n_o, memw_n_o, inta_n_o, cmd_oe_n_o, hold_o, hold_grant_out_o;
    wire nmi_o, internal_addr_latch_enable_o, bus_addr_latch_enable_o;
    wire upper_addr_latch_enable_n_o, cpu_high_byte_o, cpu_cycle_o;
    wire [4:0] cmds = {ior_n_o, iow_n_o, memr_n_o, memw_n_o, inta_n_o};
    int err_total = 0;
    int tests_run = 0;
    always #20 mclk_i = ~mclk_i;
    cbc_cycle_ctrl DUT (.*);
    cbc_cpu_model #(.LAG(2)) u_cpu (.clk_i(mclk_i), .rst_n_i(rst_n_i), .hold_i(hold_o),
                                    .hlda_o(hlda_i));
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // how: 0 channel ready, 1 zero wait, 2 left to the time-out, 3 true halt
    task automatic cpu_cyc(logic [1:0] st, logic mio, int wt, int how, logic [4:0] exp);
        logic seen;
        seen = 0;
        {s1_n_i, s0_n_i} = st;
        mem_io_sel_i = mio;
        channel_ready_i = 0;
        byte_high_enable_n_i = 0;
        addr0_i = 0;
        tick();
        {s1_n_i, s0_n_i} = `CBC_ST_IDLE;
        for (int n = 0; n < 6 && cmds === 5'h1F; n++) begin
            seen |= internal_addr_latch_enable_o;
            tick();
        end
        chk(cmds, exp);
        chk(seen, !(st == `CBC_ST_HALT && mio));
        if (how != 3) chk({cpu_cycle_o, cpu_high_byte_o}, 8'h03);
        tick(wt);
        chk(cmds, exp);
        if (how == 0) channel_ready_i = 1;
        if (how == 1) zero_wait_request_n_i = 0;
        for (int n = 0; n < 12 && ready_n_oe_n_o !== 1'b0; n++) tick();
        if (how == 3) chk({cmds, ready_n_oe_n_o}, 8'h3F);
        else chk({cmds, ready_n_oe_n_o, ready_n_o}, (how == 1) ? 8'h7E : 8'h7C);
        channel_ready_i = 1;
        zero_wait_request_n_i = 1;
        byte_high_enable_n_i = 1;
        tick(3);
    endtask
    task automatic t_cycles;
        cpu_cyc(`CBC_ST_READ, 1, 3, 0, 5'h1B);
        cpu_cyc(`CBC_ST_WRITE, 1, 0, 0, 5'h1D);
        cpu_cyc(`CBC_ST_READ, 0, 1, 0, 5'h0F);
        cpu_cyc(`CBC_ST_WRITE, 0, 2, 1, 5'h17);
        cpu_cyc(`CBC_ST_HALT, 0, 0, 0, 5'h1E);
        cpu_cyc(`CBC_ST_HALT, 1, 0, 3, 5'h1F);
        timeout_clks_i = 8'h04;
        cpu_cyc(`CBC_ST_READ, 1, 0, 2, 5'h1B);
        timeout_clks_i = 8'h00;
        $display("cycles done");
    endtask
    task automatic t_hold;
        hold_request_in_i = 1;
        dma8_addr_enable_n_i = 0;
        periph_addr0_i = 1;
        tick(2);
        chk(hold_o, 1);
        tick(4);
        chk({hold_grant_out_o, cmd_oe_n_o, byte_high_enable_n_oe_n_o}, 5'h06);
        chk(byte_high_enable_n_o, 1);
        periph_addr0_i = 0;
        dma8_addr_enable_n_i = 1;
        dma16_addr_enable_n_i = 0;
        tick(2);
        chk(byte_high_enable_n_o, 0);
        hold_request_in_i = 0;
        dma16_addr_enable_n_i = 1;
        tick(6);
        refresh_req_i = 1;
        tick(6);
        chk({hold_o, cmd_oe_n_o}, 5'h03);
        refresh_req_i = 0;
        tick(12);
        $display("hold done");
    endtask
    task automatic err_src(logic chk_en, logic rom_n, logic exp);
        chk_nmi_en_i = chk_en;
        par_nmi_en_i = 1;
        rom_select_in_n_i = rom_n;
        if (chk_en) channel_check_n_i = 0;
        else parity_error_in_n_i = 0;
        tick(6);
        chk(nmi_o, exp);
        {channel_check_n_i, parity_error_in_n_i, rom_select_in_n_i, nmi_clear_i} = 4'hF;
        tick();
        nmi_clear_i = 0;
        tick(2);
        chk(nmi_o, 0);
    endtask
    task automatic t_nmi;
        err_src(1, 1, 1);
        err_src(0, 0, 0);
        err_src(0, 1, 1);
        par_nmi_en_i = 0;
        chk_nmi_en_i = 0;
        channel_check_n_i = 0;
        tick(6);
        chk(nmi_o, 0);
        channel_check_n_i = 1;
        $display("nmi done");
    endtask
    task automatic conclude;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        tick(3);
        rst_n_i = 1;
        tick(2);
        t_cycles;
        t_hold;
        t_nmi;
        conclude;
    end
    initial begin
        #100us;
        err_total++;
        conclude;
    end
endmodule // cbc_cycle_ctrl_tb
